// *** bench/acc_partner.sv ***
// Memory, stream and coprocessor model on the access port
`timescale 1ns/100ps
module acc_partner
    import ea_prim_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rstn_i, // Reset
    input wire logic req_i, // Request
    input wire logic we_i, // Write
    input wire logic [2:0] space_i, // Space
    input wire logic [31:0] wdata_i, // Data
    input wire logic slow_i, // Wait states
    output logic ack_o, // Done
    output logic [31:0] rdata_o, // Read data
    output logic [31:0] ctl_o, // Last control write
    output logic [31:0] opa_o // Last address write
);
    localparam logic [31:0] RD = 32'h8899_aabb;
    logic [1:0] cnt;
    // Undriven between answers, so show the inverse
    assign rdata_o = ack_o ? RD : ~RD;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ack_o <= 1'b0;
            cnt <= 2'h0;
            ctl_o <= 32'h0000_0000;
            opa_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= 1'b0;
            if (req_i && !ack_o && cnt >= {slow_i, slow_i})
            begin
                ack_o <= 1'b1;
                cnt <= 2'h0;
                if (we_i && space_i == SP_CONTROL)
                    ctl_o <= wdata_i;
                if (we_i && space_i == SP_OPADDR)
                    opa_o <= wdata_i;
            end
            else if (req_i && !ack_o)
                cnt <= cnt + 2'h1;
        end
    end
endmodule : acc_partner

// *** bench/coproc_ea_primitive_handler_tb_top.sv ***
// Testbench for the primitive handler
`timescale 1ns/100ps
module coproc_ea_primitive_handler_tb_top;
    import ea_prim_pkg::*;
    logic clk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, slow = 0, er;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000, prdata, rdata, rd, ctl, opa, aaddr, awdata;
    logic pready, pslverr, areq, awe, ack, irq;
    logic [2:0] aspace, asize;
    int fails = 0, n_tests = 0;
    coproc_ea_primitive_handler coproc_ea_primitive_handler_i (.clk_i, .rstn_i, .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .acc_req_o(areq), .acc_we_o(awe),
        .acc_space_o(aspace), .acc_addr_o(aaddr), .acc_size_o(asize), .acc_wdata_o(awdata),
        .acc_ack_i(ack), .acc_rdata_i(rdata), .irq_o(irq));
    acc_partner acc_partner_i (.clk_i, .rstn_i, .req_i(areq), .we_i(awe), .space_i(aspace),
        .wdata_i(awdata), .slow_i(slow), .ack_o(ack), .rdata_o(rdata), .ctl_o(ctl), .opa_o(opa));
    task conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        k = 0;
        do @(posedge clk_i); while (pready !== 1'b1 && ++k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 50)
        begin
            fails++;
            conclude;
        end
    endtask : apb
    task setr(input logic [3:0] i, input logic [31:0] v);
        apb(1'b1, OFF_REG_INDEX, {28'h0, i});
        apb(1'b1, OFF_REG_DATA, v);
    endtask : setr
    task getr(input logic [3:0] i);
        apb(1'b1, OFF_REG_INDEX, {28'h0, i});
        apb(1'b0, OFF_REG_DATA, 32'h0);
    endtask : getr
    task run(input logic [15:0] p, input logic [5:0] ow, input logic c, input logic [1:0] res);
        int k;
        apb(1'b1, OFF_PRIM, {16'h0, p});
        apb(1'b1, OFF_OPWORD, {26'h0, ow});
        apb(1'b1, OFF_SCAN, 32'h0000_0100);
        apb(1'b1, OFF_CTRL, {30'h0, c, 1'b1});
        k = 0;
        do apb(1'b0, OFF_STATUS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0 && ++k < 100);
        if (k >= 100)
        begin
            fails++;
            conclude;
        end
        chk("result", {30'h0, res}, {30'h0, rd[STAT_RES_LSB+:2]});
    endtask : run
    task t_addr;
        setr(4'h8, 32'h0000_1000);
        run(16'h8A00, 6'o20, 1'b0, RES_OK);
        chk("opaddr", 32'h0000_1000, opa);
        slow <= 1'b1;
        run(16'h8A00, 6'o50, 1'b0, RES_OK);
        apb(1'b0, OFF_SCAN, 32'h0);
        chk("scan", 32'h0000_0102, rd);
        chk("opaddr", 32'hffff_babb, opa);
        slow <= 1'b0;
        run(16'h8A00, 6'o20, 1'b1, RES_PROTO);
        run(16'h8A00, 6'o01, 1'b0, RES_FLINE);
        chk("control", 32'h0000_0001, {16'h0, ctl[15:0]});
    endtask : t_addr
    task t_cat;
        // Data register direct belongs to the odd categories only
        for (int c = 0; c < 8; c++)
            run({8'h90 | 8'(c), 8'h04}, 6'o01, 1'b0, c[0] ? RES_OK : RES_FLINE);
        run(16'h9703, 6'o01, 1'b0, RES_PROTO);
        run(16'h9704, 6'o01, 1'b1, RES_PROTO);
    endtask : t_cat
    task t_dir;
        setr(4'h1, 32'h1234_5678);
        run(16'hB701, 6'o01, 1'b0, RES_OK);
        getr(4'h1);
        chk("d1", 32'h1234_56bb, rd);
        run(16'hB702, 6'o11, 1'b0, RES_OK);
        getr(4'h9);
        chk("a1", 32'hffff_aabb, rd);
        run(16'hB702, 6'o74, 1'b0, RES_PROTO);
        run(16'h9703, 6'o74, 1'b0, RES_PROTO);
    endtask : t_dir
    task t_stack;
        setr(4'hF, 32'h0000_2000);
        run(16'h9701, 6'o37, 1'b0, RES_OK);
        getr(4'hF);
        chk("postinc", 32'h0000_2002, rd);
        run(16'h9701, 6'o47, 1'b0, RES_OK);
        getr(4'hF);
        chk("predec", 32'h0000_2000, rd);
        setr(4'h8, 32'h0000_1000);
        run(16'h9706, 6'o30, 1'b0, RES_OK);
        getr(4'h8);
        chk("len6", 32'h0000_1006, rd);
    endtask : t_stack
    task t_regs;
        apb(1'b0, 8'h2C, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("irq off", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h7, rd);
        chk("irq on", 32'h1, {31'h0, irq});
        apb(1'b1, OFF_IRQ_STAT, 32'h7);
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("stat clr", 32'h0, rd);
        chk("irq clr", 32'h0, {31'h0, irq});
    endtask : t_regs
    initial forever #5 clk_i = ~clk_i;
    initial
    begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_addr;
        t_regs;
        t_cat;
        t_dir;
        t_stack;
        conclude;
    end
endmodule : coproc_ea_primitive_handler_tb_top

// *** bench/ea_prim_checker.sv ***
// Port checker for the primitive handler
`timescale 1ns/100ps
module ea_prim_checker
    import ea_prim_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rstn_i, // Reset
    input wire logic psel_i, // Select
    input wire logic penable_i, // Enable
    input wire logic pready_o, // Ready
    input wire logic pslverr_o, // Error
    input wire logic acc_req_o, // Request
    input wire logic acc_we_o, // Write
    input wire logic [2:0] acc_space_o, // Space
    input wire logic [31:0] acc_addr_o, // Address
    input wire logic [2:0] acc_size_o, // Size
    input wire logic [31:0] acc_wdata_o, // Data
    input wire logic acc_ack_i // Done
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    wait_one_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("apb wait");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready pulse");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error alone");
    req_hold_a: assert property (
        acc_req_o && !acc_ack_i |=> acc_req_o && $stable(acc_addr_o) && $stable(acc_space_o))
        else $error("request dropped");
    req_gap_a: assert property (acc_req_o && acc_ack_i |=> !acc_req_o)
        else $error("no gap");
    part_size_a: assert property (acc_req_o |-> acc_size_o inside {[3'd1:3'd4]})
        else $error("part size");
    abort_word_a: assert property (acc_req_o && acc_space_o == SP_CONTROL |->
        acc_we_o && acc_size_o == 3'd2 && acc_wdata_o[15:0] == ABORT_MASK)
        else $error("abort word");
    addr_write_a: assert property (acc_req_o && acc_space_o == SP_OPADDR |->
        acc_we_o && acc_size_o == 3'd4)
        else $error("address write");
    stream_read_a: assert property (acc_req_o && acc_space_o == SP_ISTREAM |->
        !acc_we_o && acc_size_o inside {3'd2, 3'd4})
        else $error("stream read");
endmodule : ea_prim_checker
bind coproc_ea_primitive_handler ea_prim_checker ea_prim_checker_i (.clk_i, .rstn_i, .psel_i,
    .penable_i, .pready_o, .pslverr_o, .acc_req_o, .acc_we_o, .acc_space_o, .acc_addr_o,
    .acc_size_o, .acc_wdata_o, .acc_ack_i);

// *** hdl/coproc_ea_primitive_handler.sv ***
// Evaluate-address primitives: address hand-over and address-based data transfer
//
// Notes on behaviour
// - Address hand-over primitive only in general category; conditional gives protocol violation.
// - Hand-over word: bit15 repeat, bit14 pass counter, bits 11 and 9 set.
// - Extension words fetched at scan pointer, pointer advancing two per word.
// - Computed 32-bit address written to operand address interface register.
// - Hand-over needs control-alterable mode, else write 0001 to control, emulation trap.
// - Data transfer primitive only in general category; conditional gives protocol violation.
// - Category field 000..111 selects control-alterable through unrestricted classes.
// - Mode outside requested category: abort mask to control, emulation trap.
// - Write requested to unalterable address gives protocol violation.
// - Register direct accepts lengths one, two or four only.
// - Memory modes accept any length zero through 255.
// - Immediate: length one or even, toward coprocessor only.
// - Compute address, then move bytes using long words wherever possible.
// - Direction flag zero sends to coprocessor, one receives from it.
// - Predecrement lowers register first; byte on stack register lowers by two.
// - Postincrement raises register after; byte on stack register raises by two.
// - Every issue recomputes address and consumes fresh extension words.
// - Byte or word into address register is sign-extended.
// - Byte or word into data register replaces only low part.
`timescale 1ns/100ps
module coproc_ea_primitive_handler
    import ea_prim_pkg::*;
(
    input wire logic clk_i,                      // Clock, 100 MHz
    input wire logic rstn_i,                     // Asynchronous reset, active low
    input wire logic psel_i,                     // APB select
    input wire logic penable_i,                  // APB enable
    input wire logic pwrite_i,                   // APB direction
    input wire logic [APB_ADDR_W-1:0] paddr_i,   // APB byte address
    input wire logic [31:0] pwdata_i,            // APB write data
    output logic [31:0] prdata_o,                // APB read data
    output logic pready_o,                       // APB ready
    output logic pslverr_o,                      // APB error
    output logic acc_req_o,                      // Access request
    output logic acc_we_o,                       // Access is a write
    output logic [2:0] acc_space_o,              // Memory, stream or interface register
    output logic [31:0] acc_addr_o,              // Access address
    output logic [2:0] acc_size_o,               // Byte count 1..4
    output logic [31:0] acc_wdata_o,             // Write data, low bytes
    input wire logic acc_ack_i,                  // Access done
    input wire logic [31:0] acc_rdata_i,         // Read data with ack
    output logic irq_o                           // Interrupt, level
);
    typedef enum logic [3:0] {S_IDLE, S_PASS_ADDR, S_CHECK, S_EXT, S_BASE, S_INDEX, S_CALC,
        S_OPADDR, S_ABORT, S_XRD, S_XWR, S_POST, S_END} state_type;

    state_type state, next_state;
    logic [15:0] prim;
    logic cond;
    logic [2:0] mode, ea_reg;
    logic [31:0] scan, instaddr, ea, base, ext_addr, xdata;
    logic [15:0] ext_hi, ext_lo;
    logic [1:0] ext_cnt, result;
    logic [7:0] rem;
    logic [IRQ_W-1:0] irq_stat, irq_mask, next_irq_stat, irq_set;
    logic [3:0] reg_index;
    rf_if rf ();

    cpu_reg_file #(.DEPTH(16)) u_regs (.clk_i(clk_i), .port(rf.store));

    // Membership of the current mode in an allowed address category
    function automatic logic cat_ok(input logic [2:0] cat, input logic [2:0] m,
                                    input logic [2:0] r);
        logic valid, is_dn, is_an, is_rel, is_imm, data, memory, control, alter;
        valid = (m != 3'h7) || (r <= 3'h4);
        is_dn = (m == 3'h0);
        is_an = (m == 3'h1);
        is_rel = (m == 3'h7) && ((r == 3'h2) || (r == 3'h3));
        is_imm = (m == 3'h7) && (r == 3'h4);
        data = valid && !is_an;
        memory = valid && !is_dn && !is_an;
        control = (m == 3'h2) || (m == 3'h5) || (m == 3'h6) || (valid && m == 3'h7 && !is_imm);
        alter = valid && !is_rel && !is_imm;
        case (cat)
            CAT_CTRL_ALT: cat_ok = control && alter;
            CAT_DATA_ALT: cat_ok = data && alter;
            CAT_MEM_ALT: cat_ok = memory && alter;
            CAT_ALT: cat_ok = alter;
            CAT_CTRL: cat_ok = control;
            CAT_DATA: cat_ok = data;
            CAT_MEM: cat_ok = memory;
            default: cat_ok = valid;
        endcase
    endfunction : cat_ok

    // Primitive and mode decode
    logic idle, recv, is_ea, is_data, reg_direct, imm, acc_done;
    logic [7:0] len;
    logic [1:0] ext_need;
    logic [2:0] part, rd_size;
    logic [31:0] step, d16, d8, idx_val, scaled, base_sel, ea_calc, merged;
    assign idle = (state == S_IDLE);
    assign recv = prim[PRIM_DIR_BIT];
    assign is_ea = (prim[13:0] == EA_XFER_CODE);
    assign is_data = (prim[12:11] == DATA_XFER_ID);
    assign len = prim[7:0];
    assign reg_direct = (mode == 3'h0) || (mode == 3'h1);
    assign imm = (mode == 3'h7) && (ea_reg == 3'h4);
    assign ext_need = ((mode == 3'h7) && (ea_reg == 3'h1)) ? 2'h2 :
        ((mode == 3'h5) || (mode == 3'h6) || ((mode == 3'h7) && (ea_reg != 3'h1)
        && (ea_reg < 3'h4))) ? 2'h1 : 2'h0;
    assign step = ((len == 8'h01) && (ea_reg == STACK_REG)) ? 32'h0000_0002 :
        {24'h00_0000, len};
    assign part = (rem >= 8'h04) ? 3'h4 : rem[2:0];
    assign rd_size = (imm && !recv && (rem == 8'h01)) ? 3'h2 : part;
    assign acc_done = acc_req_o && acc_ack_i;

    // Address arithmetic
    assign d16 = {{16{ext_lo[15]}}, ext_lo};
    assign d8 = {{24{ext_lo[7]}}, ext_lo[7:0]};
    assign idx_val = ext_lo[11] ? rf.rd_data : {{16{rf.rd_data[15]}}, rf.rd_data[15:0]};
    assign scaled = idx_val << ext_lo[10:9];
    assign base_sel = (mode == 3'h7) ? ext_addr : base;
    assign ea_calc = (mode == 3'h4) ? base - step :
        ((mode == 3'h2) || (mode == 3'h3)) ? base :
        ((mode == 3'h5) || ((mode == 3'h7) && (ea_reg == 3'h2))) ? base_sel + d16 :
        ((mode == 3'h6) || ((mode == 3'h7) && (ea_reg == 3'h3))) ? base_sel + d8 + scaled :
        ((mode == 3'h7) && (ea_reg == 3'h1)) ? {ext_hi, ext_lo} : d16;
    assign merged = (mode == 3'h1) ? ((len == 8'h01) ? {{24{xdata[7]}}, xdata[7:0]} :
        (len == 8'h02) ? {{16{xdata[15]}}, xdata[15:0]} : xdata) :
        (len == 8'h01) ? {rf.rd_data[31:8], xdata[7:0]} :
        (len == 8'h02) ? {rf.rd_data[31:16], xdata[15:0]} : xdata;

    // APB decode; writes take effect on the edge that completes the access
    logic apb_commit, apb_wr, hit_reg_data, unmapped, apb_err, start;
    logic [31:0] apb_rd;
    assign apb_commit = psel_i && penable_i && pready_o;
    assign apb_wr = apb_commit && pwrite_i && !pslverr_o;
    assign hit_reg_data = (paddr_i == OFF_REG_DATA);
    assign unmapped = (paddr_i > OFF_REG_DATA) || (paddr_i[1:0] != 2'h0);
    assign apb_err = unmapped || (hit_reg_data && !idle);
    assign start = apb_wr && idle && (paddr_i == OFF_CTRL) && pwdata_i[CTRL_START_BIT];
    assign apb_rd = (paddr_i == OFF_CTRL) ? {30'h0, cond, 1'b0} :
        (paddr_i == OFF_PRIM) ? {16'h0000, prim} :
        (paddr_i == OFF_OPWORD) ? {26'h000_0000, mode, ea_reg} :
        (paddr_i == OFF_SCAN) ? scan :
        (paddr_i == OFF_INSTADDR) ? instaddr :
        (paddr_i == OFF_STATUS) ? {28'h000_0000, prim[PRIM_REPEAT_BIT], result, !idle} :
        (paddr_i == OFF_EA) ? ea :
        (paddr_i == OFF_IRQ_STAT) ? {29'h0000_0000, irq_stat} :
        (paddr_i == OFF_IRQ_MASK) ? {29'h0000_0000, irq_mask} :
        (paddr_i == OFF_REG_INDEX) ? {28'h000_0000, reg_index} :
        (hit_reg_data && idle) ? rf.rd_data : WORD_RESET;

    // Register file port: software while idle, the sequencer otherwise
    logic fsm_we;
    assign fsm_we = ((state == S_CALC) && (mode == 3'h4)) || ((state == S_POST) && (mode == 3'h3))
        || ((state == S_XWR) && reg_direct && recv);
    assign rf.rd_addr = idle ? reg_index : (state == S_BASE) ? {1'b1, ea_reg} :
        (state == S_INDEX) ? ext_lo[15:12] : {mode[0], ea_reg};
    assign rf.we = fsm_we || (idle && apb_wr && hit_reg_data);
    assign rf.wr_addr = idle ? reg_index : (state == S_XWR) ? {mode[0], ea_reg} : {1'b1, ea_reg};
    assign rf.wr_data = idle ? pwdata_i : (state == S_CALC) ? ea_calc :
        (state == S_POST) ? base + step : merged;

    // Access port request fields
    logic want_acc, next_we;
    logic [2:0] next_space, next_size;
    logic [31:0] next_addr, next_wdata;
    assign want_acc = (state == S_PASS_ADDR) || (state == S_OPADDR) || (state == S_ABORT) ||
        ((state == S_EXT) && (ext_cnt != 2'h0)) ||
        ((state == S_XRD) && (rem != 8'h00) && !(reg_direct && !recv)) ||
        ((state == S_XWR) && !(reg_direct && recv));
    assign next_space = (state == S_PASS_ADDR) ? SP_INSTADDR :
        (state == S_OPADDR) ? SP_OPADDR : (state == S_ABORT) ? SP_CONTROL :
        (state == S_EXT) ? SP_ISTREAM :
        (state == S_XRD) ? (recv ? SP_OPERAND : imm ? SP_ISTREAM : SP_MEM) :
        (recv ? SP_MEM : SP_OPERAND);
    assign next_we = (state != S_EXT) && (state != S_XRD);
    assign next_addr = ((state == S_EXT) || ((state == S_XRD) && imm)) ? scan : ea;
    assign next_size = (state == S_EXT) ? 3'h2 : (state == S_ABORT) ? 3'h2 :
        (state == S_XRD) ? rd_size : (state == S_XWR) ? part : 3'h4;
    assign next_wdata = (state == S_PASS_ADDR) ? instaddr : (state == S_OPADDR) ? ea :
        (state == S_ABORT) ? {16'h0000, ABORT_MASK} : xdata;

    // Sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE: if (start) next_state = prim[PRIM_PASS_BIT] ? S_PASS_ADDR : S_CHECK;
            S_PASS_ADDR: if (acc_done) next_state = S_CHECK;
            S_CHECK:
            begin
                if ((!is_ea && !is_data) || cond) next_state = S_END;
                else if (is_ea) next_state = cat_ok(CAT_CTRL_ALT, mode, ea_reg) ? S_EXT : S_ABORT;
                else if (!cat_ok(prim[10:8], mode, ea_reg)) next_state = S_ABORT;
                else if (recv && !cat_ok(CAT_ALT, mode, ea_reg)) next_state = S_END;
                else if (reg_direct && (len != 8'h01) && (len != 8'h02) && (len != 8'h04))
                    next_state = S_END;
                else if (imm && (recv || ((len != 8'h01) && len[0]))) next_state = S_END;
                else if (reg_direct || imm) next_state = S_XRD;
                else next_state = S_EXT;
            end
            S_EXT: if (ext_cnt == 2'h0) next_state = S_BASE;
            S_BASE: next_state = S_INDEX;
            S_INDEX: next_state = S_CALC;
            S_CALC: next_state = is_ea ? S_OPADDR : S_XRD;
            S_OPADDR: if (acc_done) next_state = S_END;
            S_ABORT: if (acc_done) next_state = S_END;
            S_XRD:
            begin
                if (rem == 8'h00) next_state = S_POST;
                else if ((reg_direct && !recv) || acc_done) next_state = S_XWR;
            end
            S_XWR: if ((reg_direct && recv) || acc_done) next_state = S_XRD;
            S_POST: next_state = S_END;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i) state <= S_IDLE;
        else state <= next_state;
    end

    // Outcome of the checks
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i) result <= RES_OK;
        else if (state == S_CHECK && next_state == S_END) result <= RES_PROTO;
        else if (state == S_CHECK && next_state == S_ABORT) result <= RES_FLINE;
        else if (state == S_CHECK) result <= RES_OK;
    end

    // Software-written operands, held while a primitive runs
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prim <= 16'h0000;
            cond <= 1'b0;
            mode <= 3'h0;
            ea_reg <= 3'h0;
            instaddr <= WORD_RESET;
            reg_index <= 4'h0;
        end
        else if (apb_wr && idle)
        begin
            if (paddr_i == OFF_PRIM) prim <= pwdata_i[15:0];
            if (paddr_i == OFF_CTRL) cond <= pwdata_i[CTRL_COND_BIT];
            if (paddr_i == OFF_OPWORD) {mode, ea_reg} <= pwdata_i[5:0];
            if (paddr_i == OFF_INSTADDR) instaddr <= pwdata_i;
            if (paddr_i == OFF_REG_INDEX) reg_index <= pwdata_i[3:0];
        end
    end

    // Scan pointer and extension words; a fresh set is consumed on every issue
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scan <= WORD_RESET;
            ext_cnt <= 2'h0;
            ext_hi <= 16'h0000;
            ext_lo <= 16'h0000;
            ext_addr <= WORD_RESET;
        end
        else if (apb_wr && idle && (paddr_i == OFF_SCAN)) scan <= pwdata_i;
        else if (state == S_CHECK)
        begin
            ext_cnt <= ext_need;
            ext_addr <= scan;
        end
        else if (state == S_EXT && acc_done)
        begin
            scan <= scan + 32'h0000_0002;
            ext_cnt <= ext_cnt - 2'h1;
            ext_hi <= ext_lo;
            ext_lo <= acc_rdata_i[15:0];
        end
        else if (state == S_XRD && acc_done && imm && !recv)
            scan <= scan + {29'h0000_0000, rd_size};
    end

    // Address, transfer data and remaining byte count
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ea <= WORD_RESET;
            base <= WORD_RESET;
            xdata <= WORD_RESET;
            rem <= 8'h00;
        end
        else
        begin
            if (state == S_CHECK) rem <= len;
            if (state == S_INDEX) base <= rf.rd_data;
            if (state == S_CALC) ea <= ea_calc;
            if (state == S_XRD && reg_direct && !recv) xdata <= rf.rd_data;
            else if (state == S_XRD && acc_done) xdata <= acc_rdata_i;
            if (state == S_XWR && next_state == S_XRD)
            begin
                ea <= ea + {29'h0000_0000, part};
                rem <= rem - {5'h00, part};
            end
        end
    end

    // Access port: request held until acknowledged
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            acc_req_o <= 1'b0;
            acc_we_o <= 1'b0;
            acc_space_o <= SP_MEM;
            acc_addr_o <= WORD_RESET;
            acc_size_o <= 3'h0;
            acc_wdata_o <= WORD_RESET;
        end
        else if (acc_done) acc_req_o <= 1'b0;
        else if (want_acc && !acc_req_o)
        begin
            acc_req_o <= 1'b1;
            acc_we_o <= next_we;
            acc_space_o <= next_space;
            acc_addr_o <= next_addr;
            acc_size_o <= next_size;
            acc_wdata_o <= next_wdata;
        end
    end

    // Interrupts: a completion event wins over a same-cycle clear
    assign irq_set = (state == S_END) ? {result == RES_FLINE, result == RES_PROTO, 1'b1} : 3'h0;
    assign next_irq_stat = irq_set |
        (irq_stat & ~((apb_wr && paddr_i == OFF_IRQ_STAT) ? pwdata_i[IRQ_W-1:0] : 3'h0));

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_stat <= 3'h0;
            irq_mask <= IRQ_MASK_RESET;
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            if (apb_wr && paddr_i == OFF_IRQ_MASK) irq_mask <= pwdata_i[IRQ_W-1:0];
            irq_o <= |(next_irq_stat & ((apb_wr && paddr_i == OFF_IRQ_MASK) ?
                pwdata_i[IRQ_W-1:0] : irq_mask));
        end
    end

    // APB answer: one wait state, ready for a single cycle
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= WORD_RESET;
        end
        else
        begin
            pready_o <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && apb_err;
            if (psel_i && penable_i && !pready_o)
                prdata_o <= (pwrite_i || apb_err) ? WORD_RESET : apb_rd;
        end
    end
endmodule : coproc_ea_primitive_handler

// *** hdl/cpu_reg_file.sv ***
// Data and address register file, registered read port
`timescale 1ns/100ps
module cpu_reg_file
#(
    parameter int DEPTH = 16
)
(
    input wire logic clk_i, // Clock
    rf_if.store port        // Read and write port
);
    logic [31:0] mem [DEPTH];

    // Contents are not reset; software loads them before use
    always_ff @(posedge clk_i)
    begin
        if (port.we)
        begin
            mem[port.wr_addr] <= port.wr_data;
        end
        port.rd_data <= mem[port.rd_addr];
    end
endmodule : cpu_reg_file

// *** hdl/ea_prim_pkg.sv ***
// Constants shared by the effective-address primitive handler and its bench models
package ea_prim_pkg;
    // APB register offsets
    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [APB_ADDR_W-1:0] OFF_PRIM = 8'h04;
    localparam logic [APB_ADDR_W-1:0] OFF_OPWORD = 8'h08;
    localparam logic [APB_ADDR_W-1:0] OFF_SCAN = 8'h0C;
    localparam logic [APB_ADDR_W-1:0] OFF_INSTADDR = 8'h10;
    localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 8'h14;
    localparam logic [APB_ADDR_W-1:0] OFF_EA = 8'h18;
    localparam logic [APB_ADDR_W-1:0] OFF_IRQ_STAT = 8'h1C;
    localparam logic [APB_ADDR_W-1:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [APB_ADDR_W-1:0] OFF_REG_INDEX = 8'h24;
    localparam logic [APB_ADDR_W-1:0] OFF_REG_DATA = 8'h28;
    // Control and status fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_COND_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RES_LSB = 1;
    localparam int STAT_REPEAT_BIT = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_PROTO_BIT = 1;
    localparam int IRQ_FLINE_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // Result codes
    localparam logic [1:0] RES_OK = 2'h0;
    localparam logic [1:0] RES_PROTO = 2'h1;
    localparam logic [1:0] RES_FLINE = 2'h2;
    // Primitive word fields
    localparam int PRIM_REPEAT_BIT = 15;
    localparam int PRIM_PASS_BIT = 14;
    localparam int PRIM_DIR_BIT = 13;
    localparam logic [13:0] EA_XFER_CODE = 14'h0A00;
    localparam logic [1:0] DATA_XFER_ID = 2'h2;
    localparam logic [15:0] ABORT_MASK = 16'h0001;
    // Allowed address categories
    localparam logic [2:0] CAT_CTRL_ALT = 3'h0;
    localparam logic [2:0] CAT_DATA_ALT = 3'h1;
    localparam logic [2:0] CAT_MEM_ALT = 3'h2;
    localparam logic [2:0] CAT_ALT = 3'h3;
    localparam logic [2:0] CAT_CTRL = 3'h4;
    localparam logic [2:0] CAT_DATA = 3'h5;
    localparam logic [2:0] CAT_MEM = 3'h6;
    localparam logic [2:0] CAT_ANY = 3'h7;
    localparam logic [2:0] STACK_REG = 3'h7;
    // Access port spaces
    localparam logic [2:0] SP_MEM = 3'h0;
    localparam logic [2:0] SP_ISTREAM = 3'h1;
    localparam logic [2:0] SP_OPERAND = 3'h2;
    localparam logic [2:0] SP_OPADDR = 3'h3;
    localparam logic [2:0] SP_CONTROL = 3'h4;
    localparam logic [2:0] SP_INSTADDR = 3'h5;
endpackage : ea_prim_pkg

// *** hdl/rf_if.sv ***
// Port bundle between the handler and its processor register file
`timescale 1ns/100ps
interface rf_if;
    logic [3:0] rd_addr;
    logic [31:0] rd_data;
    logic we;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    modport owner (output rd_addr, we, wr_addr, wr_data, input rd_data);
    modport store (input rd_addr, we, wr_addr, wr_data, output rd_data);
endinterface : rf_if
